//--- core/core_flags_unit.sv
// Core flag register with ALU flag logic, reset cause flags and AHB-Lite access
//
// Overview of operation
// - Flag register accepts any instruction result; only zero, digit carry and carry store the written value.
// - Instructions affecting zero, digit carry or carry block the data write there.
// - Time-out and power-down flags ignore every instruction or bus data write.
// - Bits seven to five are unimplemented and always read zero.
// - Time-out flag set by power-up, watchdog clear, sleep; cleared by watchdog time-out.
// - Power-down flag set by power-up and watchdog clear; cleared by sleep.
// - Zero flag follows whether the arithmetic or logic result equals zero.
// - Add and subtract set digit carry from carry out of bit three.
// - Add and subtract set carry from carry out of the top bit.
// - In subtraction carry and digit carry mean no borrow when one.
// - Subtraction adds the two's complement of the second operand.
// - Rotates load carry with the bit shifted out of the source.
// - Clearing the flag register gives zero upper bits, zero flag set, others kept.
// - Power-on sets time-out and power-down, clears arithmetic flags; other resets keep them.
//
// Decided for this implementation: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none

module core_flags_unit (
   // Clock and power-on reset
   input wire logic clk,
   input wire logic rstn,
   // AHB-Lite slave
   input wire core_flags_pkg::ahb_req_t ahb,
   output logic hreadyout,
   output logic [1:0] hresp,
   output logic [31:0] hrdata,
   // Instruction issue from the execution unit
   input wire core_flags_pkg::instr_t instr,
   // Result write-back
   output logic [core_flags_pkg::DATA_W-1:0] result,
   output logic result_valid,
   // Flag register contents
   output logic [core_flags_pkg::DATA_W-1:0] core_flags,
   // Hardware events
   input wire logic wdt_timeout,
   input wire logic other_reset,
   input wire logic reset_to_value,
   input wire logic reset_pd_value,
   // Interrupt
   output logic irq
);
   import core_flags_pkg::*;

   state_t state_reg;
   state_t state_next;
   logic addr_take;
   logic [DATA_W-1:0] b_eff;
   logic cin;
   logic [DATA_W:0] sum;
   logic [NIB_W:0] nib;
   logic [DATA_W-1:0] res;
   logic aff_z;
   logic aff_arith;
   logic aff_rot;
   logic rot_c;
   logic writes;
   logic [NUM_EVT-1:0] evt;
   logic [NUM_EVT-1:0] w1c;
   logic [31:0] rd_mux;

   // ****************************************************************
   // Bus address phase decode and read mux
   // ****************************************************************
   assign addr_take = ahb.hsel & ahb.htrans[1] & ahb.hready;

   always_comb begin
      rd_mux = '0;
      unique case (ahb.haddr[7:0])
         OFS_FLAGS: rd_mux[DATA_W-1:0] = {UNIMPL_BITS, state_reg.flags};
         OFS_IRQ_STAT: rd_mux[NUM_EVT-1:0] = state_reg.irq_stat;
         OFS_IRQ_MASK: rd_mux[NUM_EVT-1:0] = state_reg.irq_mask;
         default: rd_mux = '0;
      endcase
   end

   // ****************************************************************
   // ALU and next state
   // ****************************************************************
   always_comb begin
      state_next = state_reg;
      // Subtract runs as opnd_b + ~opnd_a + 1
      cin = (instr.op == OP_SUB);
      b_eff = cin ? ~instr.opnd_a : instr.opnd_a;
      sum = {1'b0, instr.opnd_b} + {1'b0, b_eff} + {{DATA_W{1'b0}}, cin};
      nib = {1'b0, instr.opnd_b[NIB_W-1:0]} + {1'b0, b_eff[NIB_W-1:0]} + {{NIB_W{1'b0}}, cin};
      res = instr.opnd_b;
      aff_z = 1'b0;
      aff_arith = 1'b0;
      aff_rot = 1'b0;
      rot_c = 1'b0;
      writes = 1'b1;
      w1c = '0;
      unique case (instr.op)
         OP_NOP, OP_WDTCLR, OP_SLEEP: begin
            writes = 1'b0;
         end
         OP_ADD, OP_SUB: begin
            res = sum[DATA_W-1:0];
            aff_z = 1'b1;
            aff_arith = 1'b1;
         end
         OP_AND: begin
            res = instr.opnd_a & instr.opnd_b;
            aff_z = 1'b1;
         end
         OP_IOR: begin
            res = instr.opnd_a | instr.opnd_b;
            aff_z = 1'b1;
         end
         OP_XOR: begin
            res = instr.opnd_a ^ instr.opnd_b;
            aff_z = 1'b1;
         end
         OP_CLR: begin
            res = '0;
            aff_z = 1'b1;
         end
         OP_MOVW: begin
            res = instr.opnd_a;
         end
         OP_BCLR: begin
            res = instr.opnd_b & ~(8'h01 << instr.bit_sel);
         end
         OP_BSET: begin
            res = instr.opnd_b | (8'h01 << instr.bit_sel);
         end
         OP_SWAP: begin
            res = {instr.opnd_b[NIB_W-1:0], instr.opnd_b[DATA_W-1:NIB_W]};
         end
         OP_RLF: begin
            res = {instr.opnd_b[DATA_W-2:0], state_reg.flags[BIT_C]};
            rot_c = instr.opnd_b[DATA_W-1];
            aff_rot = 1'b1;
         end
         OP_RRF: begin
            res = {state_reg.flags[BIT_C], instr.opnd_b[DATA_W-1:1]};
            rot_c = instr.opnd_b[0];
            aff_rot = 1'b1;
         end
         OP_INC: begin
            res = instr.opnd_b + 8'h01;
            aff_z = 1'b1;
         end
         OP_DEC: begin
            res = instr.opnd_b - 8'h01;
            aff_z = 1'b1;
         end
         OP_COM: begin
            res = ~instr.opnd_b;
            aff_z = 1'b1;
         end
         default: begin
            writes = 1'b0;
         end
      endcase

      // Bus data phase; an instruction in the same cycle overrides it
      if (state_reg.wr_pend) begin
         unique case (state_reg.wr_addr)
            OFS_FLAGS: state_next.flags[BIT_Z:BIT_C] = ahb.hwdata[BIT_Z:BIT_C];
            OFS_IRQ_STAT: w1c = ahb.hwdata[NUM_EVT-1:0];
            OFS_IRQ_MASK: state_next.irq_mask = ahb.hwdata[NUM_EVT-1:0];
            default: w1c = '0;
         endcase
      end

      // Instruction effects, committed with the result on the same edge
      if (instr.valid) begin
         if (writes && instr.dest_flags && !(aff_z || aff_arith || aff_rot)) begin
            state_next.flags[BIT_Z:BIT_C] = res[BIT_Z:BIT_C];
         end
         if (aff_z) begin
            state_next.flags[BIT_Z] = (res == '0);
         end
         if (aff_arith) begin
            state_next.flags[BIT_DC] = nib[NIB_W];
            state_next.flags[BIT_C] = sum[DATA_W];
         end
         if (aff_rot) begin
            state_next.flags[BIT_C] = rot_c;
         end
         if (instr.op == OP_WDTCLR) begin
            state_next.flags[BIT_TO] = 1'b1;
            state_next.flags[BIT_PD] = 1'b1;
         end
         if (instr.op == OP_SLEEP) begin
            state_next.flags[BIT_TO] = 1'b1;
            state_next.flags[BIT_PD] = 1'b0;
         end
      end
      if (wdt_timeout) begin
         state_next.flags[BIT_TO] = 1'b0;
      end
      state_next.result_valid = instr.valid & writes & ~other_reset;
      if (instr.valid && writes) begin
         state_next.result = res;
      end

      // Non power-on reset keeps arithmetic flags, loads the cause flags
      if (other_reset) begin
         state_next.flags[BIT_TO] = reset_to_value;
         state_next.flags[BIT_PD] = reset_pd_value;
         state_next.flags[BIT_Z:BIT_C] = state_reg.flags[BIT_Z:BIT_C];
      end

      // Sticky events; a new event beats a clear in the same cycle
      evt = '0;
      evt[EVT_TIMEOUT] = wdt_timeout;
      evt[EVT_SLEEP] = instr.valid & (instr.op == OP_SLEEP);
      evt[EVT_RESET] = other_reset;
      state_next.irq_stat = (state_reg.irq_stat & ~w1c) | evt;

      // Address phase capture; read data registered for the data phase
      state_next.wr_pend = addr_take & ahb.hwrite;
      if (addr_take) begin
         state_next.wr_addr = ahb.haddr[7:0];
      end
      if (addr_take && !ahb.hwrite) begin
         state_next.hrdata = rd_mux;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_reg.flags <= FLAGS_POR;
         state_reg.irq_stat <= IRQ_RST;
         state_reg.irq_mask <= IRQ_RST;
         state_reg.wr_pend <= 1'b0;
         state_reg.wr_addr <= 8'h00;
         state_reg.hrdata <= 32'h0000_0000;
         state_reg.result <= 8'h00;
         state_reg.result_valid <= 1'b0;
      end else begin
         state_reg <= state_next;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign hreadyout = 1'b1;
   assign hresp = HRESP_OKAY;
   assign hrdata = state_reg.hrdata;
   assign result = state_reg.result;
   assign result_valid = state_reg.result_valid;
   assign core_flags = {UNIMPL_BITS, state_reg.flags};
   assign irq = |(state_reg.irq_stat & state_reg.irq_mask);

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   logic plain_instr;
   assign plain_instr = instr.valid & ~other_reset & ~wdt_timeout & ~state_reg.wr_pend;

   a_upper_bits_zero: assert property (core_flags[DATA_W-1:NUM_FLAGS] == UNIMPL_BITS)
      else $error("unimplemented flag bits not zero");
   a_move_stores_low: assert property (plain_instr && instr.op == OP_MOVW && instr.dest_flags
      |=> core_flags[BIT_Z:BIT_C] == $past(instr.opnd_a[BIT_Z:BIT_C]) && result_valid)
      else $error("move to flag register did not store low bits");
   a_reset_flags_locked: assert property (plain_instr && instr.op == OP_MOVW && instr.dest_flags
      |=> $stable(core_flags[BIT_TO:BIT_PD]))
      else $error("time-out or power-down changed by data write");
   a_add_suppress_write: assert property (plain_instr && instr.op == OP_ADD && instr.dest_flags
      |=> core_flags[BIT_Z] == (result == 8'h00))
      else $error("data write reached the zero flag");
   a_timeout_clears: assert property (wdt_timeout && !other_reset |=> !core_flags[BIT_TO])
      else $error("time-out flag not cleared by watchdog time-out");
   a_sleep_flags: assert property (plain_instr && instr.op == OP_SLEEP
      |=> core_flags[BIT_TO] && !core_flags[BIT_PD]
          && irq == ($past(state_reg.irq_mask[EVT_SLEEP])
          | (|($past(state_reg.irq_stat) & $past(state_reg.irq_mask)))))
      else $error("sleep did not set the expected flags");
   a_wdtclr_flags: assert property (plain_instr && instr.op == OP_WDTCLR
      |=> core_flags[BIT_TO] && core_flags[BIT_PD])
      else $error("watchdog clear did not set time-out and power-down");
   a_zero_result: assert property (plain_instr && instr.op inside {OP_AND, OP_IOR, OP_XOR, OP_COM}
      |=> result_valid && core_flags[BIT_Z] == (result == 8'h00))
      else $error("zero flag does not match result");
   a_add_carries: assert property (plain_instr && instr.op == OP_ADD
      |=> core_flags[BIT_C] == (({1'b0, $past(instr.opnd_a)} + {1'b0, $past(instr.opnd_b)}) > 9'h0ff)
          && core_flags[BIT_DC] == (({1'b0, $past(instr.opnd_a[3:0])}
          + {1'b0, $past(instr.opnd_b[3:0])}) > 5'h0f))
      else $error("add carry flags wrong");
   a_sub_no_borrow: assert property (plain_instr && instr.op == OP_SUB
      |=> core_flags[BIT_C] == ($past(instr.opnd_b) >= $past(instr.opnd_a))
          && result == $past(instr.opnd_b) - $past(instr.opnd_a))
      else $error("subtract borrow flag wrong");
   a_sub_digit_borrow: assert property (plain_instr && instr.op == OP_SUB
      |=> core_flags[BIT_DC] == ($past(instr.opnd_b[NIB_W-1:0]) >= $past(instr.opnd_a[NIB_W-1:0])))
      else $error("subtract digit borrow flag wrong");
   a_rotate_left_c: assert property (plain_instr && instr.op == OP_RLF
      |=> core_flags[BIT_C] == $past(instr.opnd_b[DATA_W-1])
          && result[0] == $past(state_reg.flags[BIT_C]))
      else $error("rotate left carry wrong");
   a_rotate_right_c: assert property (plain_instr && instr.op == OP_RRF
      |=> core_flags[BIT_C] == $past(instr.opnd_b[0])
          && result[DATA_W-1] == $past(state_reg.flags[BIT_C]))
      else $error("rotate right carry wrong");
   a_clear_pattern: assert property (plain_instr && instr.op == OP_CLR && instr.dest_flags
      |=> core_flags[BIT_Z] && $stable(core_flags[BIT_DC:BIT_C]))
      else $error("clear of flag register gave wrong pattern");
   a_clear_result: assert property (plain_instr && instr.op == OP_CLR
      |=> result == 8'h00 && core_flags[BIT_Z] && result_valid)
      else $error("clear did not give a zero result");
   a_other_reset_keeps: assert property (other_reset
      |=> $stable(core_flags[BIT_Z:BIT_C]) && core_flags[BIT_TO] == $past(reset_to_value)
          && core_flags[BIT_PD] == $past(reset_pd_value))
      else $error("other reset handled flags wrongly");
   a_reset_no_result: assert property (other_reset |=> !result_valid)
      else $error("result written back during other reset");
   a_same_edge_result: assert property (plain_instr && instr.op == OP_INC
      |=> result_valid && core_flags[BIT_Z] == (result == 8'h00))
      else $error("flag and result not committed together");

   // Bus write, swap, logic carry and event bookkeeping
   a_swap_stores_low: assert property (plain_instr && instr.op == OP_SWAP && instr.dest_flags
      |=> core_flags[BIT_Z:BIT_C] == $past(instr.opnd_b[NIB_W+2:NIB_W]))
      else $error("swap into flag register did not store low bits");
   a_bus_flags_write: assert property (state_reg.wr_pend && state_reg.wr_addr == OFS_FLAGS && !instr.valid
      && !other_reset && !wdt_timeout
      |=> core_flags[BIT_Z:BIT_C] == $past(ahb.hwdata[BIT_Z:BIT_C]) && $stable(core_flags[BIT_TO:BIT_PD]))
      else $error("bus write to flag register handled wrongly");
   a_logic_keeps_carry: assert property (plain_instr
      && instr.op inside {OP_AND, OP_IOR, OP_XOR, OP_INC, OP_DEC, OP_COM}
      |=> $stable(core_flags[BIT_DC:BIT_C]))
      else $error("logic operation changed carry flags");
   a_event_sets_stat: assert property (wdt_timeout |=> state_reg.irq_stat[EVT_TIMEOUT])
      else $error("time-out event not recorded");
   a_stat_sticky: assert property (state_reg.irq_stat[EVT_SLEEP]
      && !(state_reg.wr_pend && state_reg.wr_addr == OFS_IRQ_STAT) |=> state_reg.irq_stat[EVT_SLEEP])
      else $error("sleep event bit lost without a clear");

   c_sub_borrow: cover property (plain_instr && instr.op == OP_SUB && instr.opnd_a > instr.opnd_b);
   c_flags_bus_write: cover property (state_reg.wr_pend && state_reg.wr_addr == OFS_FLAGS);
   c_clear_flags: cover property (plain_instr && instr.op == OP_CLR && instr.dest_flags);
   c_timeout_irq: cover property (wdt_timeout ##1 irq);
   c_bus_read: cover property (addr_take && !ahb.hwrite ##1 hrdata != 32'h0000_0000);

endmodule

`default_nettype wire

//--- core/core_flags_pkg.sv
// Constants, operation codes and carrier types of the core flag register block
package core_flags_pkg;

   // ****************************************************************
   // Data path
   // ****************************************************************
   localparam int unsigned DATA_W = 8;
   localparam int unsigned NIB_W = 4;
   localparam int unsigned NUM_FLAGS = 5;
   localparam int unsigned NUM_EVT = 3;

   // ****************************************************************
   // Flag positions inside core_flags
   // ****************************************************************
   localparam int unsigned BIT_C = 0;
   localparam int unsigned BIT_DC = 1;
   localparam int unsigned BIT_Z = 2;
   localparam int unsigned BIT_PD = 3;
   localparam int unsigned BIT_TO = 4;
   localparam logic [2:0] UNIMPL_BITS = 3'h0;

   // Power-on values: time-out and power-down set, arithmetic clear
   localparam logic [NUM_FLAGS-1:0] FLAGS_POR = 5'h18;

   // ****************************************************************
   // Bus register map (byte addresses) and interrupt events
   // ****************************************************************
   localparam logic [7:0] OFS_FLAGS = 8'h00;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h04;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h08;
   localparam int unsigned EVT_TIMEOUT = 0;
   localparam int unsigned EVT_SLEEP = 1;
   localparam int unsigned EVT_RESET = 2;
   localparam logic [NUM_EVT-1:0] IRQ_RST = 3'h0;
   localparam logic [1:0] HRESP_OKAY = 2'h0;

   // ****************************************************************
   // Operations issued by the execution unit
   // ****************************************************************
   typedef enum logic [4:0] {
      OP_NOP = 5'h00,
      OP_ADD = 5'h01,
      OP_SUB = 5'h02,
      OP_AND = 5'h03,
      OP_IOR = 5'h04,
      OP_XOR = 5'h05,
      OP_CLR = 5'h06,
      OP_MOVW = 5'h07,
      OP_BCLR = 5'h08,
      OP_BSET = 5'h09,
      OP_SWAP = 5'h0a,
      OP_RLF = 5'h0b,
      OP_RRF = 5'h0c,
      OP_INC = 5'h0d,
      OP_DEC = 5'h0e,
      OP_COM = 5'h0f,
      OP_WDTCLR = 5'h10,
      OP_SLEEP = 5'h11
   } op_t;

   typedef struct packed {
      logic valid;
      op_t op;
      logic dest_flags;
      logic [DATA_W-1:0] opnd_a;
      logic [DATA_W-1:0] opnd_b;
      logic [2:0] bit_sel;
   } instr_t;

   typedef struct packed {
      logic hsel;
      logic [31:0] haddr;
      logic [1:0] htrans;
      logic hwrite;
      logic [2:0] hsize;
      logic [31:0] hwdata;
      logic hready;
   } ahb_req_t;

   typedef struct packed {
      logic [NUM_FLAGS-1:0] flags;
      logic [NUM_EVT-1:0] irq_stat;
      logic [NUM_EVT-1:0] irq_mask;
      logic wr_pend;
      logic [7:0] wr_addr;
      logic [31:0] hrdata;
      logic [DATA_W-1:0] result;
      logic result_valid;
   } state_t;

endpackage

//--- dv/exec_model.sv
// Behavioural execution unit that issues instructions to the flag block
`timescale 1ns/1ps
`default_nettype none
module exec_model (
   // Clock
   input wire logic clk,
   // Instruction issue
   output var core_flags_pkg::instr_t instr
);
   import core_flags_pkg::*;

   initial begin
      instr = '0;
   end

   // One instruction per edge; a following call keeps the stream back to back
   task automatic issue(input op_t op, input logic d, input logic [7:0] a, input logic [7:0] b,
                        input logic [2:0] s);
      @(posedge clk);
      instr <= '{1'b1, op, d, a, b, s};
   endtask

   // Released operands toggle so a stale value is never mistaken for a live one
   task automatic idle();
      @(posedge clk);
      instr.valid <= 1'b0;
      instr.opnd_a <= ~instr.opnd_a;
      instr.opnd_b <= ~instr.opnd_b;
   endtask
endmodule
`default_nettype wire

//--- dv/testbench.sv
// Self-checking bench for the core flag register block
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import core_flags_pkg::*;
   logic clk, rstn, wdt_timeout, other_reset, reset_to_value, reset_pd_value;
   logic hreadyout, result_valid, irq;
   logic [1:0] hresp;
   logic [31:0] hrdata, rd;
   logic [7:0] result, core_flags, ef, ra, rb;
   logic [23:0] q[$];
   logic [23:0] e;
   ahb_req_t breq, ahb_w;
   instr_t instr;
   int miscompares, checks_done, seed;
   op_t lo[7] = '{OP_AND, OP_IOR, OP_XOR, OP_INC, OP_DEC, OP_COM, OP_CLR};

   assign ahb_w = {breq[$bits(ahb_req_t)-1:1], hreadyout};
   exec_model i_exec (.clk(clk), .instr(instr));
   core_flags_unit i_dut (.clk(clk), .rstn(rstn), .ahb(ahb_w), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .instr(instr), .result(result), .result_valid(result_valid),
      .core_flags(core_flags), .wdt_timeout(wdt_timeout), .other_reset(other_reset),
      .reset_to_value(reset_to_value), .reset_pd_value(reset_pd_value), .irq(irq));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // ****************************************************************
   // Tasks
   // ****************************************************************
   task automatic chk(input string n, input logic [31:0] ex, input logic [31:0] got);
      checks_done++;
      if (got !== ex) begin
         miscompares++;
         $display("Error %s expected %h seen %h", n, ex, got);
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clk);
      breq.hsel <= 1'b1;
      breq.haddr <= {24'h0, a};
      breq.htrans <= 2'h2;
      breq.hwrite <= w;
      breq.hsize <= 3'h2;
      do @(posedge clk); while (hreadyout !== 1'b1);
      breq.hsel <= 1'b0;
      breq.htrans <= 2'h0;
      breq.hwdata <= wd;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
      chk("hresp", HRESP_OKAY, hresp);
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] ex, input string n);
      bus(1'b0, a, 32'h0);
      chk(n, ex, rd);
   endtask

   task automatic nap(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic ev(input logic w, input logic tv, input logic pv);
      @(posedge clk);
      wdt_timeout <= w;
      other_reset <= !w;
      reset_to_value <= tv;
      reset_pd_value <= pv;
      @(posedge clk);
      wdt_timeout <= 1'b0;
      other_reset <= 1'b0;
      nap(1);
   endtask

   // Works out the expected write-back and flags, notes them, then issues
   task automatic op(input op_t o, input logic d, input logic [7:0] a, input logic [7:0] b,
                     input logic [2:0] s = 3'h0);
      logic [8:0] r9;
      logic [4:0] h5;
      r9 = {1'b0, b};
      h5 = 5'h0;
      case (o)
         OP_ADD: begin
            r9 = a + b;
            h5 = a[3:0] + b[3:0];
         end
         OP_SUB: begin
            r9 = b + {1'b0, ~a} + 9'h1;
            h5 = b[3:0] + {1'b0, ~a[3:0]} + 5'h1;
         end
         OP_AND: r9 = a & b;
         OP_IOR: r9 = a | b;
         OP_XOR: r9 = a ^ b;
         OP_INC: r9 = b + 8'h1;
         OP_DEC: r9 = b - 8'h1;
         OP_COM: r9 = ~b;
         OP_CLR: r9 = 9'h0;
         OP_MOVW: r9 = a;
         OP_BSET: r9 = b | (9'h1 << s);
         OP_BCLR: r9 = b & ~(9'h1 << s);
         OP_SWAP: r9 = {b[3:0], b[7:4]};
         OP_RLF: r9 = {b, ef[0]};
         OP_RRF: r9 = {b[0], ef[0], b[7:1]};
         OP_WDTCLR: ef[4:3] = 2'h3;
         OP_SLEEP: ef[4:3] = 2'h2;
         default: ;
      endcase
      if (o inside {OP_ADD, OP_SUB}) begin
         ef[2:0] = {r9[7:0] == 8'h0, h5[4], r9[8]};
      end else if (o inside {OP_RLF, OP_RRF}) begin
         ef[0] = r9[8];
      end else if (o inside {OP_AND, OP_IOR, OP_XOR, OP_INC, OP_DEC, OP_COM, OP_CLR}) begin
         ef[2] = r9[7:0] == 8'h0;
      end else if (d) begin
         ef[2:0] = r9[2:0];
      end
      if (!(o inside {OP_WDTCLR, OP_SLEEP, OP_NOP})) begin
         q.push_back({d ? 8'h00 : 8'hff, r9[7:0], ef});
      end
      i_exec.issue(o, d, a, b, s);
   endtask

   // ****************************************************************
   // Result monitor and watchdog
   // ****************************************************************
   always @(posedge clk) begin
      if (rstn === 1'b1 && result_valid === 1'b1) begin
         if (q.size() == 0) begin
            chk("extra_result", 32'h0, 32'h1);
         end else begin
            e = q.pop_front();
            chk("result", e[23:16] & e[15:8], e[23:16] & result);
            chk("flags", e[7:0], core_flags);
         end
      end
   end

   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      report_and_stop();
   end

   initial begin
      seed = 32'h703b;
      breq = '0;
      rstn = 1'b0;
      wdt_timeout = 1'b0;
      other_reset = 1'b0;
      reset_to_value = 1'b0;
      reset_pd_value = 1'b1;
      ef = 8'h18;
      miscompares = 0;
      checks_done = 0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      nap(1);
      chk("core_flags", 8'h18, core_flags);
      rdchk(OFS_FLAGS, 32'h18, "flags_rd");
      rdchk(8'h0c, 32'h0, "unmapped_rd");
      $display("test reset finished");
      op(OP_ADD, 1'b0, 8'hff, 8'h01);
      op(OP_ADD, 1'b0, 8'h0f, 8'h01);
      op(OP_SUB, 1'b0, 8'h33, 8'h33);
      op(OP_SUB, 1'b0, 8'h01, 8'h00);
      op(OP_SUB, 1'b0, 8'h01, 8'h10);
      for (int i = 0; i < 24; i++) begin
         ra = 8'($random(seed));
         rb = 8'($random(seed));
         op(i[0] ? OP_SUB : OP_ADD, 1'b0, ra, rb);
      end
      foreach (lo[i]) op(lo[i], 1'b0, 8'h0f, 8'hf0);
      op(OP_RLF, 1'b0, 8'h00, 8'h80);
      op(OP_RRF, 1'b0, 8'h00, 8'h02);
      op(OP_SWAP, 1'b0, 8'h00, 8'h3c);
      i_exec.idle();
      nap(2);
      chk("core_flags", ef, core_flags);
      $display("test arithmetic finished");
      op(OP_MOVW, 1'b1, 8'hff, 8'h00);
      op(OP_ADD, 1'b1, 8'h01, 8'h01);
      op(OP_MOVW, 1'b1, 8'h02, 8'h00);
      op(OP_CLR, 1'b1, 8'h00, 8'h00);
      op(OP_BCLR, 1'b1, 8'h00, ef, 3'h4);
      op(OP_BSET, 1'b1, 8'h00, ef, 3'h7);
      op(OP_SWAP, 1'b1, 8'h00, 8'h5a);
      i_exec.idle();
      nap(2);
      chk("core_flags", ef, core_flags);
      $display("test flag destination finished");
      op(OP_SLEEP, 1'b0, 8'h00, 8'h00);
      i_exec.idle();
      nap(1);
      chk("core_flags", ef, core_flags);
      ev(1'b1, 1'b0, 1'b1);
      chk("core_flags", {3'h0, 1'b0, ef[3:0]}, core_flags);
      op(OP_WDTCLR, 1'b0, 8'h00, 8'h00);
      i_exec.idle();
      nap(1);
      chk("core_flags", ef, core_flags);
      ev(1'b0, 1'b0, 1'b1);
      ef[4:3] = 2'h1;
      chk("core_flags", ef, core_flags);
      ev(1'b0, 1'b1, 1'b0);
      ef[4:3] = 2'h2;
      chk("core_flags", ef, core_flags);
      $display("test reset cause finished");
      chk("irq", 32'h0, irq);
      rdchk(OFS_IRQ_STAT, 32'h7, "irq_stat");
      bus(1'b1, OFS_IRQ_MASK, 32'h1);
      nap(1);
      chk("irq", 32'h1, irq);
      bus(1'b1, OFS_IRQ_STAT, 32'h1);
      nap(1);
      chk("irq", 32'h0, irq);
      rdchk(OFS_IRQ_STAT, 32'h6, "irq_stat");
      bus(1'b1, OFS_IRQ_MASK, 32'h6);
      nap(1);
      chk("irq", 32'h1, irq);
      bus(1'b1, OFS_IRQ_STAT, 32'h6);
      nap(1);
      chk("irq", 32'h0, irq);
      bus(1'b1, OFS_FLAGS, 32'hff);
      ef[2:0] = 3'h7;
      rdchk(OFS_FLAGS, {24'h0, ef}, "flags_rd");
      $display("test interrupt and bus finished");
      @(posedge clk);
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      nap(1);
      chk("core_flags", 8'h18, core_flags);
      rdchk(OFS_IRQ_MASK, 32'h0, "irq_mask");
      chk("queue_left", 32'h0, q.size());
      $display("test second reset finished");
      report_and_stop();
   end
endmodule
`default_nettype wire
